// *** verilog/refdiv_clkin_cfg_pkg.sv ***
// Constants for the reference divider sync and clock input config bank
package refdiv_clkin_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // Register indices and their byte addresses (index times four)
  localparam logic [ADDR_W-1:0] REF_DIVIDER_SYNC_CONTROL_IDX = 12'h145;
  localparam logic [ADDR_W-1:0] CLOCK_INPUT_ENABLE_TYPE_IDX = 12'h146;
  localparam logic [ADDR_W-1:0] REF_DIVIDER_SYNC_CONTROL_ADDR = 12'h514;
  localparam logic [ADDR_W-1:0] CLOCK_INPUT_ENABLE_TYPE_ADDR = 12'h518;
  // Sync control field positions
  localparam int PLL_A_SYNC_EN_BIT = 6;
  localparam int PLL_A_SYNC_SRC_HI = 5;
  localparam int PLL_A_SYNC_SRC_LO = 4;
  localparam int PLL_B_SYNC_EN_BIT = 3;
  // Source codes
  localparam logic [1:0] SYNC_SRC_RSVD_0 = 2'h0;
  localparam logic [1:0] SYNC_SRC_PIN = 2'h1;
  localparam logic [1:0] SYNC_SRC_INPUT0 = 2'h2;
  localparam logic [1:0] SYNC_SRC_RSVD_3 = 2'h3;
  // Input control field positions
  localparam int SEL_PIN_EN_BIT = 7;
  localparam int SEL_PIN_POL_BIT = 6;
  localparam int INPUT2_ELIG_BIT = 5;
  localparam int INPUT1_ELIG_BIT = 4;
  localparam int INPUT0_ELIG_BIT = 3;
  localparam int INPUT2_KIND_BIT = 2;
  localparam int INPUT1_KIND_BIT = 1;
  localparam int INPUT0_KIND_BIT = 0;
  // Power-on values
  localparam logic RST_PLL_A_SYNC_EN = 1'b0;
  localparam logic [1:0] RST_PLL_A_SYNC_SRC = 2'h0;
  localparam logic RST_PLL_B_SYNC_EN = 1'b0;
  localparam logic RST_SEL_PIN_EN = 1'b0;
  localparam logic RST_SEL_PIN_POL = 1'b0;
  localparam logic [2:0] RST_AUTO_ELIGIBLE = 3'h3;
  localparam logic [2:0] RST_BUFFER_KIND = 3'h0;
  // Pin synchroniser lanes: sync pin, input 0, select pin 0, select pin 1
  localparam int PIN_LANES = 4;
  localparam int LANE_SYNC = 0;
  localparam int LANE_IN0 = 1;
  localparam int LANE_SEL0 = 2;
  localparam int LANE_SEL1 = 3;
endpackage

// *** verilog/refdiv_clkin_cfg.sv ***
// Reference divider sync and clock input configuration bank on Wishbone
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module refdiv_clkin_cfg (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [refdiv_clkin_cfg_pkg::ADDR_W-1:0] adr_i,
  input wire logic [refdiv_clkin_cfg_pkg::SEL_W-1:0] sel_i,
  input wire logic [refdiv_clkin_cfg_pkg::DATA_W-1:0] dat_i,
  output logic [refdiv_clkin_cfg_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic sync_pin_i,
  input wire logic clock_input_0_i,
  input wire logic [1:0] input_select_pins_i,
  output logic pll_a_refdiv_sync_o,
  output logic pll_b_refdiv_sync_o,
  output logic input_select_pin_enable_o,
  output logic [1:0] input_select_o,
  output logic [2:0] auto_eligible_o,
  output logic [2:0] buffer_kind_o
);
  import refdiv_clkin_cfg_pkg::*;

  logic pll_a_refdiv_sync_enable;
  logic [1:0] pll_a_refdiv_sync_source;
  logic pll_b_refdiv_sync_enable;
  logic input_select_pin_enable;
  logic input_select_pin_polarity;
  logic [2:0] auto_eligible;
  logic [2:0] buffer_kind;
  logic hit_sync_ctrl;
  logic hit_input_ctrl;
  logic wr_lane0;
  logic [7:0] read_byte;
  logic [PIN_LANES-1:0] pin_meta;
  logic [PIN_LANES-1:0] pin_sync;
  logic [PIN_LANES-1:0] pin_prev;
  logic [PIN_LANES-1:0] pin_rise;
  logic next_pll_a_sync;
  logic [1:0] next_select;

  // Bus decode; only byte lane 0 carries the 8-bit registers
  assign hit_sync_ctrl = (adr_i == REF_DIVIDER_SYNC_CONTROL_ADDR);
  assign hit_input_ctrl = (adr_i == CLOCK_INPUT_ENABLE_TYPE_ADDR);
  assign wr_lane0 = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Reserved bits read back as zero; unmapped addresses read zero
  always_comb begin
    read_byte = 8'h00;
    if (hit_sync_ctrl) begin
      read_byte[PLL_A_SYNC_EN_BIT] = pll_a_refdiv_sync_enable;
      read_byte[PLL_A_SYNC_SRC_HI:PLL_A_SYNC_SRC_LO] = pll_a_refdiv_sync_source;
      read_byte[PLL_B_SYNC_EN_BIT] = pll_b_refdiv_sync_enable;
    end else if (hit_input_ctrl) begin
      read_byte[SEL_PIN_EN_BIT] = input_select_pin_enable;
      read_byte[SEL_PIN_POL_BIT] = input_select_pin_polarity;
      read_byte[INPUT2_ELIG_BIT] = auto_eligible[2];
      read_byte[INPUT1_ELIG_BIT] = auto_eligible[1];
      read_byte[INPUT0_ELIG_BIT] = auto_eligible[0];
      read_byte[INPUT2_KIND_BIT] = buffer_kind[2];
      read_byte[INPUT1_KIND_BIT] = buffer_kind[1];
      read_byte[INPUT0_KIND_BIT] = buffer_kind[0];
    end
  end

  // Read data captured as ack rises, so it is steady while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (cyc_i && stb_i && !ack_o) begin
      dat_o <= {{(DATA_W-8){1'b0}}, read_byte};
    end
  end

  // Sync control register; reserved bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_a_refdiv_sync_enable <= RST_PLL_A_SYNC_EN;
      pll_a_refdiv_sync_source <= RST_PLL_A_SYNC_SRC;
      pll_b_refdiv_sync_enable <= RST_PLL_B_SYNC_EN;
    end else if (wr_lane0 && hit_sync_ctrl) begin
      pll_a_refdiv_sync_enable <= dat_i[PLL_A_SYNC_EN_BIT];
      pll_a_refdiv_sync_source <= dat_i[PLL_A_SYNC_SRC_HI:PLL_A_SYNC_SRC_LO];
      pll_b_refdiv_sync_enable <= dat_i[PLL_B_SYNC_EN_BIT];
    end
  end

  // Input enable and buffer type register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_select_pin_enable <= RST_SEL_PIN_EN;
      input_select_pin_polarity <= RST_SEL_PIN_POL;
      auto_eligible <= RST_AUTO_ELIGIBLE;
      buffer_kind <= RST_BUFFER_KIND;
    end else if (wr_lane0 && hit_input_ctrl) begin
      input_select_pin_enable <= dat_i[SEL_PIN_EN_BIT];
      input_select_pin_polarity <= dat_i[SEL_PIN_POL_BIT];
      auto_eligible[2] <= dat_i[INPUT2_ELIG_BIT];
      auto_eligible[1] <= dat_i[INPUT1_ELIG_BIT];
      auto_eligible[0] <= dat_i[INPUT0_ELIG_BIT];
      buffer_kind[2] <= dat_i[INPUT2_KIND_BIT];
      buffer_kind[1] <= dat_i[INPUT1_KIND_BIT];
      buffer_kind[0] <= dat_i[INPUT0_KIND_BIT];
    end
  end

  // Two-flop synchronisers for every pin; edges seen from second flop only
  genvar lane;
  generate
    for (lane = 0; lane < PIN_LANES; lane++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_meta[lane] <= 1'b0;
          pin_sync[lane] <= 1'b0;
          pin_prev[lane] <= 1'b0;
        end else begin
          pin_meta[lane] <= (lane == LANE_SYNC) ? sync_pin_i :
                            (lane == LANE_IN0) ? clock_input_0_i :
                            (lane == LANE_SEL0) ? input_select_pins_i[0] :
                            input_select_pins_i[1];
          pin_sync[lane] <= pin_meta[lane];
          pin_prev[lane] <= pin_sync[lane];
        end
      end
      assign pin_rise[lane] = pin_sync[lane] && !pin_prev[lane];
    end
  endgenerate

  // Input 0 is sampled, so only inputs well below half clk_i are seen
  always_comb begin
    next_pll_a_sync = 1'b0;
    case (pll_a_refdiv_sync_source)
      SYNC_SRC_PIN: next_pll_a_sync = pin_rise[LANE_SYNC];
      SYNC_SRC_INPUT0: next_pll_a_sync = pin_rise[LANE_IN0];
      SYNC_SRC_RSVD_0: next_pll_a_sync = 1'b0;
      SYNC_SRC_RSVD_3: next_pll_a_sync = 1'b0;
      default: next_pll_a_sync = 1'b0;
    endcase
  end

  // Selected select-pin level, corrected for polarity
  always_comb begin
    next_select = {pin_sync[LANE_SEL1], pin_sync[LANE_SEL0]};
    if (input_select_pin_polarity) begin
      next_select = ~next_select;
    end
  end

  // One-cycle divider sync pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_a_refdiv_sync_o <= 1'b0;
      pll_b_refdiv_sync_o <= 1'b0;
    end else begin
      pll_a_refdiv_sync_o <= pll_a_refdiv_sync_enable && next_pll_a_sync;
      pll_b_refdiv_sync_o <= pll_b_refdiv_sync_enable && pin_rise[LANE_SYNC];
    end
  end

  // Configuration outputs to the clock input logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_select_pin_enable_o <= RST_SEL_PIN_EN;
      input_select_o <= 2'h0;
      auto_eligible_o <= RST_AUTO_ELIGIBLE;
      buffer_kind_o <= RST_BUFFER_KIND;
    end else begin
      input_select_pin_enable_o <= input_select_pin_enable;
      // Held at zero when pins do not control selection
      input_select_o <= input_select_pin_enable ? next_select : 2'h0;
      auto_eligible_o <= auto_eligible;
      buffer_kind_o <= buffer_kind;
    end
  end
endmodule

// *** verif/refdiv_clkin_cfg_checker.sv ***
// Assertions on the ports of the sync and input control bank
`timescale 1ns/1ps
module refdiv_clkin_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic sync_pin_i,
  input wire logic clock_input_0_i,
  input wire logic pll_a_refdiv_sync_o,
  input wire logic pll_b_refdiv_sync_o,
  input wire logic input_select_pin_enable_o,
  input wire logic [1:0] input_select_o,
  input wire logic [2:0] auto_eligible_o,
  input wire logic [2:0] buffer_kind_o
);
  import refdiv_clkin_cfg_pkg::*;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] wr_byte;
  // Byte taken at the ack edge; no property locals, so free tools accept it
  always_ff @(posedge clk_i) begin
    if (ack_o && we_i) begin
      wr_byte <= dat_i[7:0];
    end
  end
  // Write lands at the ack edge, outputs follow one cycle later
  sequence s_in_wr;
    ack_o && we_i && sel_i[0] && adr_i == CLOCK_INPUT_ENABLE_TYPE_ADDR;
  endsequence
  property p_in_wr;
    s_in_wr |-> ##2 {input_select_pin_enable_o, auto_eligible_o, buffer_kind_o} ==
      {wr_byte[7], wr_byte[5:0]};
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("input control outputs stale");
  property p_ack; (cyc_i && stb_i && !ack_o) |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered in one cycle");
  property p_sel_off; !input_select_pin_enable_o |-> input_select_o == 2'h0; endproperty
  a_sel_off: assert property (p_sel_off) else $error("select active while pins disabled");
  property p_rsv; (ack_o && !we_i && adr_i == REF_DIVIDER_SYNC_CONTROL_ADDR) |->
    dat_o[31:7] == 25'h0 && dat_o[2:0] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved sync bits read nonzero");
  property p_a_one; pll_a_refdiv_sync_o |=> !pll_a_refdiv_sync_o; endproperty
  a_a_one: assert property (p_a_one) else $error("first sync pulse too long");
  property p_b_one; pll_b_refdiv_sync_o |=> !pll_b_refdiv_sync_o; endproperty
  a_b_one: assert property (p_b_one) else $error("second sync pulse too long");
  property p_a_src; pll_a_refdiv_sync_o |-> $past(sync_pin_i, 2) || $past(clock_input_0_i, 2);
  endproperty
  a_a_src: assert property (p_a_src) else $error("first sync without trigger");
  property p_b_src; pll_b_refdiv_sync_o |-> $past(sync_pin_i, 2); endproperty
  a_b_src: assert property (p_b_src) else $error("second sync without pin");
endmodule

// *** verif/tb_top.sv ***
// Register and sync pulse tests of the sync and input control bank
`timescale 1ns/1ps
module tb_top;
  import refdiv_clkin_cfg_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [11:0] adr_i = 12'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic sync_pin_i = 1'b0, clock_input_0_i = 1'b0, pll_a_refdiv_sync_o, pll_b_refdiv_sync_o;
  logic [1:0] input_select_pins_i = 2'h1, input_select_o;
  logic input_select_pin_enable_o;
  logic [2:0] auto_eligible_o, buffer_kind_o;
  int miscompares = 0, comparisons = 0, cycles = 0, na, nb;
  refdiv_clkin_cfg uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .sync_pin_i(sync_pin_i),
    .clock_input_0_i(clock_input_0_i),
    .input_select_pins_i(input_select_pins_i),
    .pll_a_refdiv_sync_o(pll_a_refdiv_sync_o),
    .pll_b_refdiv_sync_o(pll_b_refdiv_sync_o),
    .input_select_pin_enable_o(input_select_pin_enable_o),
    .input_select_o(input_select_o),
    .auto_eligible_o(auto_eligible_o),
    .buffer_kind_o(buffer_kind_o)
  );
  always #2.5 clk_i = ~clk_i;
  // Generous ceiling, run needs about two hundred cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the request until ack is sampled, then idles one cycle
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h0);
    chk("read", q, exp);
  endtask
  task automatic pulse(input logic in0);
    na = 0;
    nb = 0;
    if (in0) clock_input_0_i <= 1'b1;
    else sync_pin_i <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      if (i == 4) {sync_pin_i, clock_input_0_i} <= 2'h0;
      na += int'(pll_a_refdiv_sync_o === 1'b1);
      nb += int'(pll_b_refdiv_sync_o === 1'b1);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(REF_DIVIDER_SYNC_CONTROL_ADDR, 32'h0);
    rd(CLOCK_INPUT_ENABLE_TYPE_ADDR, 32'h18);
    chk("eligible", {29'h0, auto_eligible_o}, 32'h3);
    rd(12'h51C, 32'h0);
    $display("reset values done");
    for (int p = 0; p < 3; p++) begin
      bus(CLOCK_INPUT_ENABLE_TYPE_ADDR, 1'b1, {p != 0, p == 2, 6'h27});
      repeat (6) @(posedge clk_i);
      chk("pin enable", {31'h0, input_select_pin_enable_o}, 32'(p != 0));
      chk("select", {30'h0, input_select_o}, p == 0 ? 32'h0 : p == 1 ? 32'h1 : 32'h2);
      chk("outputs", {25'h0, auto_eligible_o, buffer_kind_o}, 32'h27);
    end
    $display("input control done");
    // Reserved bits written high must read back zero
    bus(REF_DIVIDER_SYNC_CONTROL_ADDR, 1'b1, 8'hFF);
    rd(REF_DIVIDER_SYNC_CONTROL_ADDR, 32'h78);
    for (int s = 0; s < 5; s++) begin
      bus(REF_DIVIDER_SYNC_CONTROL_ADDR, 1'b1, {1'b0, s < 4, 2'(s), s < 4, 3'h0});
      pulse(1'b0);
      chk("sync a", 32'(na), 32'(s == 1));
      chk("sync b", 32'(nb), 32'(s < 4));
      pulse(1'b1);
      chk("input0 a", 32'(na), 32'(s == 2));
      chk("input0 b", 32'(nb), 32'h0);
    end
    $display("sync pulses done");
    conclude();
  end
endmodule
bind refdiv_clkin_cfg refdiv_clkin_cfg_checker chk_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .sync_pin_i(sync_pin_i),
  .clock_input_0_i(clock_input_0_i),
  .pll_a_refdiv_sync_o(pll_a_refdiv_sync_o),
  .pll_b_refdiv_sync_o(pll_b_refdiv_sync_o),
  .input_select_pin_enable_o(input_select_pin_enable_o),
  .input_select_o(input_select_o),
  .auto_eligible_o(auto_eligible_o),
  .buffer_kind_o(buffer_kind_o)
);
